// ### dvr_pkg.sv
`default_nettype none
package dvr_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MVOL_OFS = 8'h04;
  localparam logic [7:0] CVOL_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] LVL_OFS = 8'h1C;
  localparam logic [7:0] LVL_END = 8'h2C;
  // control field positions
  localparam int CF_SRS = 0;
  localparam int CF_STEP = 1;
  localparam int CF_MIND = 3;
  localparam int CF_MAXD = 6;
  localparam int CF_GATE = 9;
  localparam int CF_GRP = 12;
  localparam int CF_PDN = 15;
  localparam int CF_MUTE = 19;
  localparam int CF_DEEM = 23;
  localparam int CF_BASE = 24;
  localparam int CF_SSPD = 26;
  // status field positions
  localparam int SF_ENV = 4;
  localparam int SF_RATED = 5;
  localparam int SF_CODE = 6;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h06000FC1;
  localparam logic [7:0] VOL_RST = 8'h10;
  // volume code arithmetic
  localparam logic [9:0] VOL_OFFSET = 10'h010;
  localparam logic [9:0] VOL_LAST = 10'h0FF;
  localparam logic [9:0] LVL_MUTE = 10'h3FF;
  localparam int GAIN_SHIFT = 15;
  // noise gate
  localparam logic [2:0] GATE_OFF = 3'h7;
  localparam int GATE_SAMPLES = 8192;
  localparam logic [13:0] GATE_LAST = 14'(GATE_SAMPLES - 1);
  // envelope timeout in base sample periods
  localparam int ENV_TIMEOUT_NUM = 100000;
  // base rate codes and shelf coefficients
  localparam logic [1:0] BASE_32 = 2'h0;
  localparam logic [1:0] BASE_44 = 2'h1;
  localparam logic [1:0] BASE_48 = 2'h2;
  localparam logic [15:0] DEEM_K32 = 16'h5000;
  localparam logic [15:0] DEEM_K44 = 16'h4000;
  localparam logic [15:0] DEEM_K48 = 16'h3C00;
endpackage
`default_nettype wire

// ### dvr_volume_ramp.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// (R1) channel dB plus master dB sets attenuation
// (R2) volume codes span +6 to -90 dB
// (R3) clamp sum; below range mutes
// (R4) range, power-down, mute, gate cause mute
// (R5) unmute uses same immediate or ramp choice
// (R6) soft ramp covers mute, unmute, volume writes
// (R7) isolated changes ramp at step-delay rate
// (R8) fresh write resets counter, constant rate
// (R9) expired counter makes next write fresh
// (R10) quick write continues envelope, recomputes rate
// (R11) linear interpolation with one sample lag
// (R12) adaptive rate clamped by min/max delay
// (R13) software sets min=max=step for constant rate
// (R14) envelope timeout about 100000 base periods
// (R15) delay counts base periods per 0.1 dB
// (R16) rates from one to 128 periods
// (R17) full-scale ramp covers 96 dB
// (R18) four channel mutes plus master volume
// (R19) de-emphasis for 32/44.1/48 single speed
// (R20) samples picked from 32 slots, two lines
// (R21) group code picks four slots, line
// (R22) gate after 8192 equal samples; 111 off
// (R23) envelope delay fits interval, then clamped
module dvr_volume_ramp #(
  parameter int ENV_TIMEOUT = dvr_pkg::ENV_TIMEOUT_NUM
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_in,
  input wire logic fsync_in,
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  output logic [95:0] analog_out_channels,
  output logic sample_valid,
  output logic [3:0] gate_active
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0] mvol;
    logic [3:0][7:0] cvol;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic sclk_q;
    logic fs_q;
    logic [31:0] sh_a;
    logic [31:0] sh_b;
    logic [4:0] bitc;
    logic [3:0] slot;
    logic [3:0][23:0] smp;
    logic [3:0][23:0] aout;
    logic aval;
    logic [3:0][9:0] cur;
    logic [3:0][7:0] stc;
    logic [3:0][13:0] gcnt;
    logic [3:0] gate;
    logic [3:0][23:0] lp;
    logic [16:0] envc;
    logic env_act;
    logic env_rated;
    logic [2:0] env_code;
    logic [9:0] env_dl;
  } dvr_st_t;

  dvr_st_t st;
  dvr_st_t next_st;
  logic frame_tick;
  logic vol_wr;
  logic [3:0][9:0] tgt;
  logic [3:0] mutes;
  logic [2:0] rate;

  // highest set bit of a count
  function automatic logic [4:0] dvr_msb(input logic [16:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < 17; k++) begin
      if (v[k]) r = 5'(k);
    end
    return r;
  endfunction

  // gate depth code to watched upper bits
  function automatic logic [4:0] dvr_gate_w(input logic [2:0] c);
    case (c)
      3'h0: return 5'h0D;
      3'h1: return 5'h0E;
      3'h2: return 5'h0F;
      3'h3: return 5'h10;
      3'h4: return 5'h11;
      3'h5: return 5'h12;
      3'h6: return 5'h18;
      default: return 5'h00;
    endcase
  endfunction

  assign frame_tick = fsync_in & ~st.fs_q;
  // write commits at the edge that sees pready
  assign vol_wr = psel & penable & pwrite & st.pready & ~st.pslverr &
                  (paddr >= dvr_pkg::MVOL_OFS) & (paddr < dvr_pkg::STAT_OFS);

  // whole next-state computation
  always_comb begin
    logic acc, err, sedge;
    logic [31:0] rd, wa;
    logic [7:0] vold, dv;
    logic [9:0] sum, s, dl;
    logic [5:0] dcode;
    logic [2:0] mind, maxd, grp;
    logic [7:0] lim;
    logic [23:0] x, gm, y;
    logic signed [24:0] e2;
    logic signed [41:0] pk;
    logic signed [41:0] p, q;
    logic [16:0] mant;
    logic [15:0] k;
    logic [4:0] sh;
    acc = psel & penable & ~st.pready;
    err = 1'b0;
    sedge = sclk_in & ~st.sclk_q;
    rd = 32'h0;
    wa = 32'h0;
    vold = 8'h00;
    dv = 8'h00;
    sum = 10'h000;
    s = 10'h000;
    dl = 10'h000;
    dcode = 6'h00;
    mind = st.ctrl[dvr_pkg::CF_MIND +: 3];
    maxd = st.ctrl[dvr_pkg::CF_MAXD +: 3];
    grp = st.ctrl[dvr_pkg::CF_GRP +: 3];
    lim = 8'h00;
    x = 24'h0;
    gm = 24'h0;
    y = 24'h0;
    e2 = '0;
    pk = '0;
    p = '0;
    q = '0;
    mant = 17'h00000;
    k = 16'h0000;
    sh = 5'h00;
    tgt = '0;
    mutes = 4'h0;
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.aval = 1'b0;
    next_st.sclk_q = sclk_in;
    next_st.fs_q = fsync_in;
    case (st.ctrl[dvr_pkg::CF_BASE +: 2])
      dvr_pkg::BASE_32: k = dvr_pkg::DEEM_K32;
      dvr_pkg::BASE_44: k = dvr_pkg::DEEM_K44;
      default: k = dvr_pkg::DEEM_K48;
    endcase

    // apb read decode, answer one cycle into access
    if (paddr == dvr_pkg::CTRL_OFS) begin
      rd = st.ctrl;
    end else if (paddr == dvr_pkg::MVOL_OFS) begin
      rd = {24'h0, st.mvol};
    end else if (paddr >= dvr_pkg::CVOL_OFS && paddr < dvr_pkg::STAT_OFS && paddr[1:0] == 2'h0) begin
      rd = {24'h0, st.cvol[2'(paddr[7:2] - dvr_pkg::CVOL_OFS[7:2])]};
    end else if (paddr == dvr_pkg::STAT_OFS) begin
      rd[3:0] = st.gate;
      rd[dvr_pkg::SF_ENV] = st.env_act;
      rd[dvr_pkg::SF_RATED] = st.env_rated;
      rd[dvr_pkg::SF_CODE +: 3] = st.env_code;
    end else if (paddr >= dvr_pkg::LVL_OFS && paddr < dvr_pkg::LVL_END && paddr[1:0] == 2'h0) begin
      rd = {22'h0, st.cur[2'(paddr[7:2] - dvr_pkg::LVL_OFS[7:2])]};
    end else begin
      err = 1'b1;
    end
    if (acc) begin
      next_st.pready = 1'b1;
      next_st.prdata = rd;
      next_st.pslverr = err;
    end

    // apb write commit
    if (psel && penable && pwrite && st.pready && !st.pslverr) begin
      if (paddr == dvr_pkg::CTRL_OFS) next_st.ctrl = pwdata;
      if (paddr == dvr_pkg::MVOL_OFS) begin
        vold = st.mvol;
        next_st.mvol = pwdata[7:0];
      end
      for (int i = 0; i < 4; i++) begin
        if (paddr == dvr_pkg::CVOL_OFS + 8'(4 * i)) begin
          vold = st.cvol[i];
          next_st.cvol[i] = pwdata[7:0];
        end
      end
    end

    // envelope counter runs on base ticks
    if (frame_tick && st.env_act) begin
      if (st.envc == 17'(ENV_TIMEOUT - 1)) begin
        next_st.env_act = 1'b0; // R9 R14
        next_st.env_rated = 1'b0;
      end else begin
        next_st.envc = st.envc + 17'h1;
      end
    end
    // each volume write either starts or extends an envelope
    if (vol_wr) begin
      dv = (pwdata[7:0] > vold) ? pwdata[7:0] - vold : vold - pwdata[7:0];
      dl = {dv, 2'b00}; // R15
      next_st.envc = 17'h0; // R8 R10
      next_st.env_act = 1'b1;
      next_st.env_dl = dl;
      if (!st.env_act) begin
        next_st.env_rated = 1'b0; // R8 R9
      end else begin
        // previous change spread over the interval: one sample lag
        if (st.env_dl == 10'h0) begin
          dcode = {3'h0, maxd}; // R23
        end else begin
          dcode = {1'b0, dvr_msb(st.envc)} - {1'b0, dvr_msb({7'h0, st.env_dl})}; // R11 R23
        end
        if (dcode[5] || dcode < {3'h0, mind}) dcode = {3'h0, mind}; // R12
        if (dcode > {3'h0, maxd}) dcode = {3'h0, maxd}; // R12
        next_st.env_code = dcode[2:0];
        next_st.env_rated = 1'b1; // R10
      end
    end
    rate = (st.env_act && st.env_rated) ? st.env_code :
           {1'b0, st.ctrl[dvr_pkg::CF_STEP +: 2]}; // R7 R10
    lim = (8'h01 << rate) - 8'h01; // R16

    // tdm receive: fsync restarts slot count
    if (frame_tick) begin
      next_st.bitc = 5'h00;
      next_st.slot = 4'h0;
    end else if (sedge) begin
      next_st.sh_a = {st.sh_a[30:0], serial_in_a};
      next_st.sh_b = {st.sh_b[30:0], serial_in_b};
      next_st.bitc = st.bitc + 5'h01;
      if (st.bitc == 5'h1F) begin
        next_st.slot = st.slot + 4'h1;
        wa = grp[2] ? {st.sh_b[30:0], serial_in_b} : {st.sh_a[30:0], serial_in_a}; // R20 R21
        if (st.slot[3:2] == grp[1:0]) begin
          next_st.smp[st.slot[1:0]] = wa[31:8]; // R21
        end
      end
    end

    // per channel: gate, target, ramp, shelf, gain
    for (int i = 0; i < 4; i++) begin
      sum = {2'b00, st.cvol[i]} + {2'b00, st.mvol}; // R1
      s = sum - dvr_pkg::VOL_OFFSET; // R2
      if (sum < dvr_pkg::VOL_OFFSET) tgt[i] = 10'h000; // R3
      else tgt[i] = {s[7:0], 2'b00};
      mutes[i] = (sum >= dvr_pkg::VOL_OFFSET && s > dvr_pkg::VOL_LAST) | // R3
                 st.ctrl[dvr_pkg::CF_PDN + i] | st.ctrl[dvr_pkg::CF_MUTE + i] | st.gate[i]; // R4 R18
      if (mutes[i]) tgt[i] = dvr_pkg::LVL_MUTE; // R4
      if (frame_tick) begin
        x = st.smp[i];
        gm = ~(24'hFFFFFF >> dvr_gate_w(st.ctrl[dvr_pkg::CF_GATE +: 3]));
        if (st.ctrl[dvr_pkg::CF_GATE +: 3] == dvr_pkg::GATE_OFF ||
            ((x & gm) != gm && (x & gm) != 24'h0)) begin
          next_st.gcnt[i] = 14'h0; // R22
          next_st.gate[i] = 1'b0;
        end else if (st.gcnt[i] == dvr_pkg::GATE_LAST) begin
          next_st.gate[i] = 1'b1; // R22
        end else begin
          next_st.gcnt[i] = st.gcnt[i] + 14'h1;
        end
        // immediate or stepped move toward target
        if (!st.ctrl[dvr_pkg::CF_SRS]) begin
          next_st.cur[i] = tgt[i]; // R4 R5
          next_st.stc[i] = 8'h00;
        end else if (st.cur[i] == tgt[i]) begin
          next_st.stc[i] = 8'h00;
        end else if (st.stc[i] >= lim) begin
          next_st.stc[i] = 8'h00; // R15
          if (st.cur[i] < tgt[i]) next_st.cur[i] = st.cur[i] + 10'h1; // R5 R6 R17
          else next_st.cur[i] = st.cur[i] - 10'h1; // R6 R7
        end else begin
          next_st.stc[i] = st.stc[i] + 8'h01;
        end
        // first-order shelf only at single speed, low base rates
        e2 = $signed({x[23], x}) - $signed({st.lp[i][23], st.lp[i]});
        pk = e2 * $signed({1'b0, k});
        next_st.lp[i] = st.lp[i] + pk[39:16];
        if (st.ctrl[dvr_pkg::CF_DEEM] && st.ctrl[dvr_pkg::CF_SSPD])
          y = st.lp[i] + 24'(e2 >>> 2); // R19
        else
          y = x;
        // 6.02 dB per shift, linear mantissa within an octave, exact at octave edges
        mant = 17'h10000 - {2'b00, st.cur[i][5:0], 9'h000};
        sh = 5'(dvr_pkg::GAIN_SHIFT) + {1'b0, st.cur[i][9:6]};
        p = $signed(y) * $signed({1'b0, mant});
        q = p >>> sh;
        if (st.cur[i] == dvr_pkg::LVL_MUTE) next_st.aout[i] = 24'h0; // R3 R4
        else if (q[41:23] != '0 && q[41:23] != '1)
          next_st.aout[i] = q[41] ? 24'h800000 : 24'h7FFFFF;
        else next_st.aout[i] = q[23:0];
        next_st.aval = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.ctrl <= dvr_pkg::CTRL_RST;
      st.mvol <= dvr_pkg::VOL_RST;
      st.cvol <= {4{dvr_pkg::VOL_RST}};
      st.cur <= {4{dvr_pkg::LVL_MUTE}};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign analog_out_channels = st.aout;
  assign sample_valid = st.aval;
  assign gate_active = st.gate;

  default clocking dvr_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // apb answers exactly one cycle after access starts
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  // a muted channel outputs zero samples
  mute_zero_a: assert property (sample_valid && $past(st.cur[0]) == dvr_pkg::LVL_MUTE |-> // R3
    analog_out_channels[23:0] == 24'h0) else $error("muted channel not silent");
  // power-down with immediate mode mutes on next tick
  pdn_mute_a: assert property (frame_tick && !st.ctrl[dvr_pkg::CF_SRS] && st.ctrl[dvr_pkg::CF_PDN] // R4
    |=> st.cur[0] == dvr_pkg::LVL_MUTE) else $error("power down did not mute");
  // immediate mode lands on the summed target
  imm_target_a: assert property (frame_tick && !st.ctrl[dvr_pkg::CF_SRS] |=> // R1 R5
    st.cur[1] == $past(tgt[1])) else $error("immediate level wrong");
  // soft ramp moves one internal step at most per tick
  ramp_step_a: assert property (frame_tick && st.ctrl[dvr_pkg::CF_SRS] |=> // R6 R7
    (st.cur[0] - $past(st.cur[0]) <= 10'h1) || ($past(st.cur[0]) - st.cur[0] <= 10'h1))
    else $error("ramp step too large");
  // no step before the delay count is reached
  ramp_hold_a: assert property (frame_tick && st.ctrl[dvr_pkg::CF_SRS] // R15
    && st.stc[2] < (8'h01 << rate) - 8'h01 |=> $stable(st.cur[2])) else $error("early ramp step");
  // gate engages only after the full run of samples
  gate_run_a: assert property ($rose(st.gate[0]) |-> $past(st.gcnt[0]) == dvr_pkg::GATE_LAST) // R22
    else $error("gate engaged early");
  // depth 111 keeps the gate open
  gate_off_a: assert property (frame_tick && st.ctrl[dvr_pkg::CF_GATE +: 3] == dvr_pkg::GATE_OFF // R22
    |=> !st.gate[3] && st.gcnt[3] == 14'h0) else $error("disabled gate engaged");
  // every volume write restarts the envelope counter
  env_reset_a: assert property (vol_wr |=> st.env_act && st.envc == 17'h0) // R8 R10
    else $error("envelope counter not reset");
  // first write after timeout keeps constant rate
  env_fresh_a: assert property (vol_wr && !st.env_act |=> !st.env_rated) // R9
    else $error("fresh write changed rate");
  // counter expiry ends the envelope
  env_expire_a: assert property (frame_tick && st.env_act && !vol_wr && st.envc == 17'(ENV_TIMEOUT - 1) // R14
    |=> !st.env_act) else $error("envelope did not expire");
  // bounds only meaningful when min does not exceed max
  logic mind_le_max;
  assign mind_le_max = st.ctrl[dvr_pkg::CF_MIND +: 3] <= st.ctrl[dvr_pkg::CF_MAXD +: 3];

  // adaptive rate stays inside configured bounds
  rate_bound_a: assert property (vol_wr && st.env_act && mind_le_max |=> // R12
    st.env_code >= $past(st.ctrl[dvr_pkg::CF_MIND +: 3]) && st.env_code <= $past(st.ctrl[dvr_pkg::CF_MAXD +: 3]))
    else $error("rate out of bounds");

  gate_on_c: cover property ($rose(st.gate[0]));
  env_rated_c: cover property ($rose(st.env_rated));
  ramp_done_c: cover property (st.ctrl[dvr_pkg::CF_SRS] && $changed(st.cur[0]) ##1 st.cur[0] == tgt[0]);
  pslverr_c: cover property (pready && pslverr);

endmodule // dvr_volume_ramp
`default_nettype wire

// ### dvr_tdm_source.sv
`timescale 1ns/1ps
`default_nettype none
// serial audio host: sends frames of 32-bit slots on two lines, msb first
module dvr_tdm_source (
  input wire logic pclk,
  output logic sclk_in,
  output logic fsync_in,
  output logic serial_in_a,
  output logic serial_in_b
);
  logic [31:0] slot_a [16];
  logic [31:0] slot_b [16];

  // idle lines at time zero
  initial begin
    sclk_in = 1'b0;
    fsync_in = 1'b0;
    serial_in_a = 1'b0;
    serial_in_b = 1'b0;
  end

  // one frame: fsync rise, then ns slots, bit clock at a quarter of pclk
  task automatic send_frame(input int ns);
    @(posedge pclk);
    fsync_in <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int b = 0; b < ns * 32; b++) begin
      serial_in_a <= slot_a[b / 32][31 - b % 32];
      serial_in_b <= slot_b[b / 32][31 - b % 32];
      sclk_in <= 1'b0;
      repeat (2) @(posedge pclk);
      sclk_in <= 1'b1;
      fsync_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    // released: clock and frame sync low, data shows the inverse of the last bit
    sclk_in <= 1'b0;
    fsync_in <= 1'b0;
    serial_in_a <= ~serial_in_a;
    serial_in_b <= ~serial_in_b;
  endtask
endmodule // dvr_tdm_source
`default_nettype wire

// ### dvr_volume_ramp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dvr_volume_ramp_tb;
  localparam int ENV_T = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [95:0] aout;
  logic [3:0] gate_active;
  logic pready, pslverr, e, sclk_in, fsync_in, serial_in_a, serial_in_b, sample_valid;
  int errors = 0;
  int total_checks = 0;
  int svc = 0;

  // 200 MHz clock and output pulse count
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (sample_valid === 1'b1) svc++;

  dvr_volume_ramp #(.ENV_TIMEOUT(ENV_T)) dvr_volume_ramp_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_in(sclk_in),
    .fsync_in(fsync_in), .serial_in_a(serial_in_a), .serial_in_b(serial_in_b),
    .analog_out_channels(aout), .sample_valid(sample_valid), .gate_active(gate_active)
  );
  dvr_tdm_source dvr_tdm_source_i (
    .pclk(pclk), .sclk_in(sclk_in), .fsync_in(fsync_in), .serial_in_a(serial_in_a), .serial_in_b(serial_in_b)
  );

  task automatic results;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", w, x, g);
    end
  endtask

  // one apb transfer, read data and error land in q and e
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected pready: expected 1, seen %b", pready);
      results();
    end
  endtask

  task automatic frames(input int n, input int ns);
    repeat (n) dvr_tdm_source_i.send_frame(ns);
  endtask

  task automatic lvl(input int k);
    apb(0, dvr_pkg::LVL_OFS + 8'(4 * k), 0);
  endtask

  // control word, gate off, 48k base, single speed
  function automatic logic [31:0] cw(input logic srs, input logic [1:0] st, input logic [2:0] mn,
      input logic [2:0] mx, input logic [2:0] g, input logic [3:0] pd, input logic [3:0] mu);
    return {5'h00, 1'b1, dvr_pkg::BASE_48, 1'b0, mu, pd, g, dvr_pkg::GATE_OFF, mx, mn, st, srs};
  endfunction

  // level expected from channel and master codes
  function automatic logic [31:0] expl(input int c, input int m);
    int s;
    s = c + m - int'(dvr_pkg::VOL_OFFSET);
    if (s > 255) return 32'(dvr_pkg::LVL_MUTE);
    return (s < 0) ? 32'h0 : 32'(s * 4);
  endfunction

  function automatic logic [31:0] pat(input logic ln, input int i);
    return {ln ? 4'h5 : 4'hA, 4'(i), ln ? 24'h3C9600 : 24'hC35A00};
  endfunction

  task automatic t_reset;
    apb(0, dvr_pkg::CTRL_OFS, 0);
    chk("ctrl reset", dvr_pkg::CTRL_RST, q);
    for (int k = 0; k < 5; k++) begin
      apb(0, dvr_pkg::MVOL_OFS + 8'(4 * k), 0);
      chk("volume reset", 32'(dvr_pkg::VOL_RST), q);
    end
    apb(1, 8'h40, 32'h0000FFFF);
    chk("unmapped write error", 1, 32'(e));
    apb(0, 8'h40, 0);
    chk("unmapped read error", 1, 32'(e));
    chk("unmapped read data", 0, q);
    $display("test reset done");
  endtask

  task automatic t_sum;
    int v [4] = '{32, 255, 0, 16};
    apb(1, dvr_pkg::CTRL_OFS, cw(0, 0, 0, 7, 0, 0, 0));
    for (int k = 0; k < 4; k++) apb(1, dvr_pkg::CVOL_OFS + 8'(4 * k), 32'(v[k]));
    for (int m = 24; m >= 0; m -= 24) begin
      apb(1, dvr_pkg::MVOL_OFS, 32'(m));
      frames(2, 4);
      for (int k = 0; k < 4; k++) begin
        lvl(k);
        chk("summed level", expl(v[k], m), q);
      end
    end
    $display("test sum done");
  endtask

  task automatic t_mute;
    apb(1, dvr_pkg::MVOL_OFS, 32'h10);
    for (int k = 0; k < 4; k++) apb(1, dvr_pkg::CVOL_OFS + 8'(4 * k), 32'h10);
    for (int p = 1; p >= 0; p--) begin
      apb(1, dvr_pkg::CTRL_OFS, cw(0, 0, 0, 7, 0, p ? 4'h8 : 4'h0, p ? 4'h2 : 4'h0));
      frames(2, 4);
      for (int k = 0; k < 4; k++) begin
        lvl(k);
        chk("mute level", (p != 0 && k % 2 == 1) ? 32'h3FF : 32'h40, q);
      end
    end
    $display("test mute done");
  endtask

  task automatic t_ramp;
    logic [31:0] a;
    for (int d = 0; d < 2; d++) begin
      apb(1, dvr_pkg::CTRL_OFS, cw(1, 2'(d), 3'(d), 3'(d), 0, 0, 0));
      apb(1, dvr_pkg::CVOL_OFS, 32'h14 - 32'(4 * d));
      frames(1, 4);
      lvl(0);
      a = q;
      frames(4, 4);
      lvl(0);
      chk("ramp steps per 4 periods", 32'(4 >> d), (q > a) ? q - a : a - q);
    end
    frames(12, 4);
    lvl(0);
    chk("ramp end level", 32'h40, q);
    apb(1, dvr_pkg::CTRL_OFS, cw(1, 0, 0, 0, 0, 0, 4'h4));
    frames(3, 4);
    lvl(2);
    chk("ramped mute midway", 1, 32'(q > 32'h40 && q < 32'h3FF));
    $display("test ramp done");
  endtask

  task automatic t_env;
    apb(1, dvr_pkg::CTRL_OFS, cw(1, 0, 1, 3, 0, 0, 0));
    for (int i = 0; i < 3; i++) begin
      frames(i == 1 ? 3 : ENV_T + 2, 4);
      apb(1, dvr_pkg::CVOL_OFS, 32'h20 + 32'(8 * i));
      frames(1, 4);
      apb(0, dvr_pkg::STAT_OFS, 0);
      chk("rate adapted", 32'(i == 1), 32'(q[dvr_pkg::SF_RATED]));
      if (i == 1) chk("adapted code clamp", 32'h1, 32'(q[dvr_pkg::SF_CODE +: 3]));
    end
    $display("test envelope done");
  endtask

  task automatic t_slots;
    int n;
    for (int i = 0; i < 16; i++) begin
      dvr_tdm_source_i.slot_a[i] = pat(1'b0, i);
      dvr_tdm_source_i.slot_b[i] = pat(1'b1, i);
    end
    apb(1, dvr_pkg::CVOL_OFS, 32'h10);
    for (int g = 0; g < 8; g++) begin
      apb(1, dvr_pkg::CTRL_OFS, cw(0, 0, 0, 7, 3'(g), 0, 0));
      n = svc;
      frames(2, 4 * (g % 4 + 1));
      chk("output pulses", 2, 32'(svc - n));
      for (int k = 0; k < 4; k++) begin
        q = pat(g > 3, 4 * (g % 4) + k);
        chk("channel sample", 32'(q[31:8]), 32'(aout[24 * k +: 24]));
      end
    end
    $display("test slots done");
  endtask

  // shelf step response, then noise gate over a long silent run
  task automatic t_gate;
    logic [31:0] c;
    for (int i = 0; i < 16; i++) begin
      dvr_tdm_source_i.slot_a[i] = 32'h00000000;
      dvr_tdm_source_i.slot_b[i] = 32'h00000000;
    end
    c = cw(0, 0, 0, 7, 0, 0, 0);
    apb(1, dvr_pkg::CTRL_OFS, c | (32'h1 << dvr_pkg::CF_DEEM));
    frames(2, 4);
    chk("shelf step response", 1, 32'(aout[23:0] != 24'h0));
    apb(1, dvr_pkg::CTRL_OFS, (c | (32'h1 << dvr_pkg::CF_DEEM)) & ~(32'h1 << dvr_pkg::CF_SSPD));
    frames(1, 4);
    chk("shelf off at double speed", 0, 32'(aout != 96'h0));
    apb(1, dvr_pkg::CTRL_OFS, c & ~(32'h7 << dvr_pkg::CF_GATE));
    frames(8000, 0);
    chk("gate before full run", 0, 32'(gate_active));
    frames(300, 0);
    chk("gate after full run", 32'hF, 32'(gate_active));
    lvl(0);
    chk("gate mute level", 32'(dvr_pkg::LVL_MUTE), q);
    apb(1, dvr_pkg::CTRL_OFS, c);
    frames(2, 0);
    chk("gate released", 0, 32'(gate_active));
    lvl(0);
    chk("gate release level", 32'h40, q);
    $display("test gate done");
  endtask

  // reset for 10 cycles, then the scenarios
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sum();
    t_mute();
    t_ramp();
    t_env();
    t_slots();
    t_gate();
    results();
  end
endmodule // dvr_volume_ramp_tb
`default_nettype wire
